//--- common/vtc_defs.vh
// Constants for the per-port VLAN classify and tag edit block.
// Assumes byte-wide frames without FCS, first byte of destination first.
`ifndef VTC_DEFS_VH
`define VTC_DEFS_VH
`define VTC_TPID_C 16'h8100
`define VTC_TPID_S 16'h88A8
`define VTC_VID_DEFAULT 12'h001
`define VTC_VID_MAX 12'hFFE
`define VTC_VID_NONE 12'h000
`define VTC_CFI_CLEAR 1'b0
`define VTC_PRI_DEFAULT 3'h0
`define VTC_SA_OFS 5'd6
`define VTC_MAC_LEN 5'd12
`define VTC_OUTER_TCI 5'd14
`define VTC_INNER_TYPE 5'd16
`define VTC_INNER_TCI 5'd18
`define VTC_HDR_CAP 5'd20
`define VTC_MIN_RUNT 5'd14
`define VTC_TAG_LEN 5'd4
`define VTC_MIN_LEN 16'd60
`define VTC_FCS_LAST 2'h3
`define VTC_CRC_INIT 32'hFFFFFFFF
`define VTC_CRC_POLY 32'hEDB88320
`define VTC_QINQ_OFF 2'h0
`define VTC_QINQ_UPLINK 2'h1
`define VTC_QINQ_CUSTOMER 2'h2
`endif

//--- design/vtc_crc32.v
// Byte-wise Ethernet CRC-32 accumulator, reflected form.
// Assumes the caller clears it before the first byte of each frame.
`timescale 1ns/100ps
`include "vtc_defs.vh"
module vtc_crc32 (
    input wire clk,
    input wire rst_n,
    input wire clear,
    input wire en,
    input wire [7:0] data,
    output reg [31:0] crc_reg
);
    reg [31:0] crc_next;
    integer b;
    always @* begin
        crc_next = crc_reg ^ {24'h000000, data};
        for (b = 0; b < 8; b = b + 1) begin
            if (crc_next[0]) begin
                crc_next = (crc_next >> 1) ^ `VTC_CRC_POLY;
            end else begin
                crc_next = crc_next >> 1;
            end
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= `VTC_CRC_INIT;
        end else if (clear) begin
            crc_reg <= `VTC_CRC_INIT;
        end else if (en) begin
            crc_reg <= crc_next;
        end
    end
endmodule

//--- design/vtc_vlan_port.v
// Per-port VLAN classify, forward decision and egress tag editor.
// Assumes frames arrive without FCS; outData is always accepted.
`timescale 1ns/100ps
`include "vtc_defs.vh"
module vtc_vlan_port #(
    parameter PORTS = 8,
    parameter PORT_ID = 0,
    parameter TABLE_SIZE = 255,
    parameter IDX_W = 8
) (
    input wire clk,
    input wire rst_n,
    input wire inValid,
    input wire [7:0] inData,
    input wire inLast,
    output wire inReady,
    output wire outValid,
    output wire [7:0] outData,
    output wire outLast,
    input wire tblWrEn,
    input wire [IDX_W-1:0] tblWrIndex,
    input wire tblWrValid,
    input wire [11:0] tblWrVid,
    input wire [PORTS-1:0] tblWrMembers,
    input wire tblWrLearnOff,
    input wire portCfgWrEn,
    input wire [11:0] portCfgPvid,
    input wire [2:0] portCfgPriority,
    input wire portCfgTagged,
    input wire portCfgFilter,
    input wire [1:0] portCfgQinq,
    input wire [11:0] portCfgServiceVid,
    output wire fwdValid,
    output wire [PORTS-1:0] fwdMask,
    output wire fwdDrop,
    output wire fwdFlood,
    output wire [11:0] classVid,
    output wire learnValid,
    output wire [47:0] learnMac,
    output wire [11:0] learnVid
);
    localparam ST_CAPTURE = 3'h0;
    localparam ST_DECIDE = 3'h1;
    localparam ST_EMIT = 3'h2;
    localparam ST_PASS = 3'h3;
    localparam ST_PAD = 3'h4;
    localparam ST_FCS = 3'h5;
    localparam ST_DISCARD = 3'h6;

    function [7:0] tagByte;
        input [31:0] tag;
        input [1:0] n;
        begin
            case (n)
                2'h0: tagByte = tag[31:24];
                2'h1: tagByte = tag[23:16];
                2'h2: tagByte = tag[15:8];
                default: tagByte = tag[7:0];
            endcase
        end
    endfunction

    function [PORTS:0] popCount;
        input [PORTS-1:0] m;
        integer p;
        begin
            popCount = {(PORTS+1){1'b0}};
            for (p = 0; p < PORTS; p = p + 1) begin
                popCount = popCount + {{PORTS{1'b0}}, m[p]};
            end
        end
    endfunction

    reg [2:0] state_reg;
    reg [4:0] hdrCnt_reg;
    reg lastSeen_reg;
    reg [4:0] emitIdx_reg;
    reg [4:0] emitLen_reg;
    reg [4:0] rest_reg;
    reg outS_reg;
    reg outC_reg;
    reg [31:0] sTag_reg;
    reg [31:0] cTag_reg;
    reg [15:0] outCnt_reg;
    reg [1:0] fcsIdx_reg;
    reg inReady_reg;
    reg outValid_reg;
    reg [7:0] outData_reg;
    reg outLast_reg;
    reg fwdValid_reg;
    reg [PORTS-1:0] fwdMask_reg;
    reg fwdDrop_reg;
    reg fwdFlood_reg;
    reg [11:0] classVid_reg;
    reg learnValid_reg;
    reg [47:0] learnMac_reg;
    reg [11:0] learnVid_reg;
    reg [11:0] port_default_vlan_id_reg;
    reg [2:0] pri_reg;
    reg tagged_reg;
    reg filter_reg;
    reg [1:0] qinq_reg;
    reg [11:0] svcVid_reg;
    reg [7:0] hdrMem [0:19];
    reg [TABLE_SIZE-1:0] vlanValid_reg;
    reg [TABLE_SIZE-1:0] vlanNoLearn_reg;
    reg [11:0] vlanVid_reg [0:TABLE_SIZE-1];
    reg [PORTS-1:0] vlanMem_reg [0:TABLE_SIZE-1];
    wire [31:0] crcVal;

    assign inReady = inReady_reg;
    assign outValid = outValid_reg;
    assign outData = outData_reg;
    assign outLast = outLast_reg;
    assign fwdValid = fwdValid_reg;
    assign fwdMask = fwdMask_reg;
    assign fwdDrop = fwdDrop_reg;
    assign fwdFlood = fwdFlood_reg;
    assign classVid = classVid_reg;
    assign learnValid = learnValid_reg;
    assign learnMac = learnMac_reg;
    assign learnVid = learnVid_reg;

    wire take = inValid && inReady_reg;

    wire [15:0] typeOuter = {hdrMem[`VTC_MAC_LEN],
        hdrMem[`VTC_MAC_LEN + 5'd1]};
    wire [15:0] typeInner = {hdrMem[`VTC_INNER_TYPE],
        hdrMem[`VTC_INNER_TYPE + 5'd1]};
    wire hasS = (hdrCnt_reg == `VTC_HDR_CAP) && (typeOuter == `VTC_TPID_S)
        && (typeInner == `VTC_TPID_C);
    wire hasC = hasS || ((hdrCnt_reg >= `VTC_INNER_TYPE)
        && (typeOuter == `VTC_TPID_C));
    wire [7:0] tciHi = hdrMem[`VTC_OUTER_TCI];
    wire [7:0] tciLo = hdrMem[`VTC_OUTER_TCI + 5'd1];
    wire [11:0] tagVid = {tciHi[3:0], tciLo};
    wire [2:0] clsPri = hasC ? tciHi[7:5] : pri_reg;
    wire [11:0] clsVid = (hasC && tagVid != `VTC_VID_NONE) ? tagVid
        : port_default_vlan_id_reg;
    wire vidOk = (clsVid != `VTC_VID_NONE) && (clsVid <= `VTC_VID_MAX);

    reg hit;
    reg hitNoLearn;
    reg [PORTS-1:0] hitMem;
    integer k;
    always @* begin
        hit = 1'b0;
        hitNoLearn = 1'b0;
        hitMem = {PORTS{1'b0}};
        for (k = 0; k < TABLE_SIZE; k = k + 1) begin
            if (vlanValid_reg[k] && vlanVid_reg[k] == clsVid) begin
                hit = 1'b1;
                hitNoLearn = vlanNoLearn_reg[k];
                hitMem = vlanMem_reg[k];
            end
        end
    end

    wire drop = !vidOk || !hit || (hdrCnt_reg < `VTC_MIN_RUNT)
        || (filter_reg && !hitMem[PORT_ID]);
    wire keepS = hasS && (qinq_reg != `VTC_QINQ_CUSTOMER);
    wire addS = !hasS && (qinq_reg == `VTC_QINQ_UPLINK);
    wire keepC = hasC && (hasS || tagged_reg);
    wire addC = !hasC && tagged_reg;
    wire [4:0] restPos = hasS ? `VTC_HDR_CAP
        : (hasC ? `VTC_INNER_TYPE : `VTC_MAC_LEN);
    wire [4:0] sCnt = (keepS || addS) ? `VTC_TAG_LEN : 5'd0;
    wire [4:0] cCnt = (keepC || addC) ? `VTC_TAG_LEN : 5'd0;
    wire [4:0] emitLen = `VTC_MAC_LEN + sCnt + cCnt + hdrCnt_reg - restPos;
    wire [31:0] sExist = {hdrMem[`VTC_MAC_LEN], hdrMem[`VTC_MAC_LEN + 5'd1],
        hdrMem[`VTC_OUTER_TCI], hdrMem[`VTC_OUTER_TCI + 5'd1]};
    wire [31:0] cExist = hasS ? {`VTC_TPID_C, hdrMem[`VTC_INNER_TCI],
        hdrMem[`VTC_INNER_TCI + 5'd1]} : {`VTC_TPID_C, tciHi, tciLo};

    reg [4:0] j;
    reg [4:0] pos;
    reg [7:0] emitByte;
    always @* begin
        j = emitIdx_reg - `VTC_MAC_LEN;
        pos = 5'd0;
        emitByte = 8'h00;
        if (emitIdx_reg < `VTC_MAC_LEN) begin
            emitByte = hdrMem[emitIdx_reg];
        end else if (outS_reg && j < `VTC_TAG_LEN) begin
            emitByte = tagByte(sTag_reg, j[1:0]);
        end else begin
            if (outS_reg) begin
                j = j - `VTC_TAG_LEN;
            end
            if (outC_reg && j < `VTC_TAG_LEN) begin
                emitByte = tagByte(cTag_reg, j[1:0]);
            end else begin
                if (outC_reg) begin
                    j = j - `VTC_TAG_LEN;
                end
                pos = rest_reg + j;
                emitByte = hdrMem[pos];
            end
        end
    end

    wire [15:0] cntInc = outCnt_reg + 16'd1;
    wire [2:0] afterData = (cntInc < `VTC_MIN_LEN) ? ST_PAD : ST_FCS;
    wire crcEnNow = (state_reg == ST_EMIT) || (state_reg == ST_PAD)
        || (state_reg == ST_PASS && take);

    vtc_crc32 u_crc (
        .clk(clk),
        .rst_n(rst_n),
        .clear(state_reg == ST_DECIDE),
        .en(crcEnNow),
        .data(state_reg == ST_PASS ? inData
            : (state_reg == ST_EMIT ? emitByte : 8'h00)),
        .crc_reg(crcVal)
    );

    always @(posedge clk) begin
        if (state_reg == ST_CAPTURE && take) begin
            hdrMem[hdrCnt_reg] <= inData;
        end
    end

    integer t;
    integer m;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (t = 0; t < TABLE_SIZE; t = t + 1) begin
                vlanValid_reg[t] <= 1'b0;
                vlanNoLearn_reg[t] <= 1'b0;
                vlanVid_reg[t] <= `VTC_VID_NONE;
                vlanMem_reg[t] <= {PORTS{1'b0}};
            end
            vlanValid_reg[0] <= 1'b1;
            vlanVid_reg[0] <= `VTC_VID_DEFAULT;
            vlanMem_reg[0] <= {PORTS{1'b1}};
            port_default_vlan_id_reg <= `VTC_VID_DEFAULT;
            pri_reg <= `VTC_PRI_DEFAULT;
            tagged_reg <= 1'b0;
            filter_reg <= 1'b0;
            qinq_reg <= `VTC_QINQ_OFF;
            svcVid_reg <= `VTC_VID_DEFAULT;
        end else begin
            if (tblWrEn && tblWrIndex < TABLE_SIZE) begin
                vlanValid_reg[tblWrIndex] <= tblWrValid;
                vlanVid_reg[tblWrIndex] <= tblWrVid;
                vlanMem_reg[tblWrIndex] <= tblWrMembers;
                vlanNoLearn_reg[tblWrIndex] <= tblWrLearnOff
                    && popCount(tblWrMembers) == 2;
            end
            if (portCfgWrEn) begin
                port_default_vlan_id_reg <= portCfgPvid;
                pri_reg <= portCfgPriority;
                tagged_reg <= portCfgTagged;
                filter_reg <= portCfgFilter;
                qinq_reg <= portCfgQinq;
                svcVid_reg <= portCfgServiceVid;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_CAPTURE;
            hdrCnt_reg <= 5'd0;
            lastSeen_reg <= 1'b0;
            emitIdx_reg <= 5'd0;
            emitLen_reg <= 5'd0;
            rest_reg <= 5'd0;
            outS_reg <= 1'b0;
            outC_reg <= 1'b0;
            sTag_reg <= 32'h00000000;
            cTag_reg <= 32'h00000000;
            outCnt_reg <= 16'd0;
            fcsIdx_reg <= 2'h0;
            inReady_reg <= 1'b1;
            outValid_reg <= 1'b0;
            outData_reg <= 8'h00;
            outLast_reg <= 1'b0;
            fwdValid_reg <= 1'b0;
            fwdMask_reg <= {PORTS{1'b0}};
            fwdDrop_reg <= 1'b0;
            fwdFlood_reg <= 1'b0;
            classVid_reg <= `VTC_VID_NONE;
            learnValid_reg <= 1'b0;
            learnMac_reg <= 48'h000000000000;
            learnVid_reg <= `VTC_VID_NONE;
        end else begin
            outValid_reg <= 1'b0;
            outLast_reg <= 1'b0;
            fwdValid_reg <= 1'b0;
            learnValid_reg <= 1'b0;
            case (state_reg)
                ST_CAPTURE: begin
                    if (take) begin
                        hdrCnt_reg <= hdrCnt_reg + 5'd1;
                        lastSeen_reg <= inLast;
                        if (inLast || hdrCnt_reg == `VTC_HDR_CAP - 5'd1) begin
                            state_reg <= ST_DECIDE;
                            inReady_reg <= 1'b0;
                        end
                    end
                end
                ST_DECIDE: begin
                    fwdValid_reg <= 1'b1;
                    fwdDrop_reg <= drop;
                    classVid_reg <= clsVid;
                    fwdFlood_reg <= hitNoLearn;
                    fwdMask_reg <= drop ? {PORTS{1'b0}}
                        : hitMem & ~({{(PORTS-1){1'b0}}, 1'b1} << PORT_ID);
                    learnValid_reg <= !drop && !hitNoLearn;
                    learnVid_reg <= clsVid;
                    for (m = 0; m < 6; m = m + 1) begin
                        learnMac_reg[8*(5-m) +: 8] <= hdrMem[`VTC_SA_OFS + m];
                    end
                    outS_reg <= keepS || addS;
                    outC_reg <= keepC || addC;
                    sTag_reg <= addS ? {`VTC_TPID_S, clsPri, `VTC_CFI_CLEAR,
                        svcVid_reg} : sExist;
                    cTag_reg <= addC ? {`VTC_TPID_C, clsPri, `VTC_CFI_CLEAR,
                        clsVid} : cExist;
                    rest_reg <= restPos;
                    emitLen_reg <= emitLen;
                    emitIdx_reg <= 5'd0;
                    outCnt_reg <= 16'd0;
                    if (drop) begin
                        state_reg <= lastSeen_reg ? ST_CAPTURE : ST_DISCARD;
                        inReady_reg <= 1'b1;
                        hdrCnt_reg <= 5'd0;
                    end else begin
                        state_reg <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    outValid_reg <= 1'b1;
                    outData_reg <= emitByte;
                    outCnt_reg <= cntInc;
                    emitIdx_reg <= emitIdx_reg + 5'd1;
                    if (emitIdx_reg == emitLen_reg - 5'd1) begin
                        state_reg <= lastSeen_reg ? afterData : ST_PASS;
                        inReady_reg <= !lastSeen_reg;
                    end
                end
                ST_PASS: begin
                    if (take) begin
                        outValid_reg <= 1'b1;
                        outData_reg <= inData;
                        outCnt_reg <= cntInc;
                        if (inLast) begin
                            state_reg <= afterData;
                            inReady_reg <= 1'b0;
                        end
                    end
                end
                ST_PAD: begin
                    outValid_reg <= 1'b1;
                    outData_reg <= 8'h00;
                    outCnt_reg <= cntInc;
                    if (cntInc == `VTC_MIN_LEN) begin
                        state_reg <= ST_FCS;
                    end
                end
                ST_FCS: begin
                    outValid_reg <= 1'b1;
                    outData_reg <= ~crcVal[8*fcsIdx_reg +: 8];
                    fcsIdx_reg <= fcsIdx_reg + 2'h1;
                    if (fcsIdx_reg == `VTC_FCS_LAST) begin
                        outLast_reg <= 1'b1;
                        state_reg <= ST_CAPTURE;
                        inReady_reg <= 1'b1;
                        hdrCnt_reg <= 5'd0;
                    end
                end
                ST_DISCARD: begin
                    if (take && inLast) begin
                        state_reg <= ST_CAPTURE;
                    end
                end
                default: begin
                    state_reg <= ST_CAPTURE;
                    inReady_reg <= 1'b1;
                    hdrCnt_reg <= 5'd0;
                end
            endcase
        end
    end
endmodule

//--- dv/vtc_vlan_port_chk.sv
// Assertion checker for the VLAN classify and tag edit port.
// Assumes it is bound onto vtc_vlan_port and sees its ports only.
`timescale 1ns/100ps
`include "vtc_defs.vh"
module vtc_vlan_port_chk #(
    parameter PORTS = 8,
    parameter PORT_ID = 0
) (
    input wire clk,
    input wire rst_n,
    input wire outValid,
    input wire outLast,
    input wire fwdValid,
    input wire [PORTS-1:0] fwdMask,
    input wire fwdDrop,
    input wire fwdFlood,
    input wire [11:0] classVid,
    input wire learnValid,
    input wire [11:0] learnVid
);
    int byteCnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byteCnt_reg <= 0;
        end else if (outLast) begin
            byteCnt_reg <= 0;
        end else if (outValid) begin
            byteCnt_reg <= byteCnt_reg + 1;
        end
    end
    a_fwd_pulse: assert property (fwdValid |=> !fwdValid)
        else $error("Decision pulse too long.");
    a_mask_self: assert property (fwdValid |-> !fwdMask[PORT_ID])
        else $error("Receiving port in mask.");
    a_drop_mask: assert property (fwdValid && fwdDrop |-> fwdMask == '0)
        else $error("Dropped frame has a mask.");
    a_vid_range: assert property (fwdValid && !fwdDrop |->
        classVid != 12'h000 && classVid <= `VTC_VID_MAX)
        else $error("Accepted VID out of range.");
    a_learn_vid: assert property (learnValid |->
        fwdValid && !fwdFlood && learnVid == classVid)
        else $error("Learn VID differs from class VID.");
    a_last_pulse: assert property (outLast |-> outValid ##1 !outLast)
        else $error("Bad end of frame pulse.");
    a_min_len: assert property (outLast |-> byteCnt_reg >= 63)
        else $error("Frame shorter than 64 bytes.");
    a_drop_silent: assert property (fwdValid && fwdDrop |->
        (!outValid) [*8])
        else $error("Dropped frame was sent.");
    c_drop: cover property (fwdValid && fwdDrop);
    c_flood: cover property (fwdValid && fwdFlood);
    c_frame: cover property (outLast);
endmodule

bind vtc_vlan_port vtc_vlan_port_chk #(.PORTS(PORTS), .PORT_ID(PORT_ID))
    vtc_vlan_port_chk_i (.clk(clk), .rst_n(rst_n), .outValid(outValid),
    .outLast(outLast), .fwdValid(fwdValid), .fwdMask(fwdMask),
    .fwdDrop(fwdDrop), .fwdFlood(fwdFlood), .classVid(classVid),
    .learnValid(learnValid), .learnVid(learnVid));

//--- dv/vtc_link_partner.sv
// Link partner model: sends queued frame bytes, collects egress bytes.
// Assumes the bench loads txq with one whole frame at a time.
`timescale 1ns/100ps
module vtc_link_partner (
    input wire clk,
    input wire inReady,
    input wire outValid,
    input wire [7:0] outData,
    output logic inValid,
    output logic [7:0] inData,
    output logic inLast
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic took;
    initial begin
        inValid = 1'b0;
        inData = 8'h00;
        inLast = 1'b0;
    end
    always @(posedge clk) begin
        took <= inValid && inReady;
        if (outValid) begin
            rxq.push_back(outData);
        end
    end
    always @(negedge clk) begin
        if (took) begin
            void'(txq.pop_front());
        end
        if (txq.size() > 0) begin
            inValid = 1'b1;
            inData = txq[0];
            inLast = txq.size() == 1;
        end else begin
            inValid = 1'b0;
            inData = ~inData;
            inLast = 1'b0;
        end
    end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for one VLAN classify and tag edit port.
// Assumes port 0 of eight and the link partner model beside it.
`timescale 1ns/100ps
`include "vtc_defs.vh"
module tb_top;
    typedef logic [7:0] vtc_bq_t[$];
    localparam [47:0] srcMac = 48'h020000000011;
    localparam [31:0] tagC5 = {`VTC_TPID_C, 16'h0005};
    localparam [31:0] tagS7 = {`VTC_TPID_S, 16'h0007};
    logic clk, rst_n, inValid, inLast, inReady, outValid, outLast;
    logic [7:0] inData, outData, tblWrIndex, tblWrMembers, fwdMask;
    logic tblWrEn, tblWrValid, tblWrLearnOff, portCfgWrEn;
    logic [11:0] tblWrVid, portCfgPvid, portCfgServiceVid;
    logic [11:0] classVid, learnVid;
    logic [2:0] portCfgPriority;
    logic [1:0] portCfgQinq;
    logic portCfgTagged, portCfgFilter, fwdValid, fwdDrop, fwdFlood;
    logic learnValid;
    logic [47:0] learnMac;
    int n_fail, checked;

    vtc_vlan_port vtc_vlan_port_i (.clk(clk), .rst_n(rst_n),
        .inValid(inValid),
        .inData(inData), .inLast(inLast), .inReady(inReady),
        .outValid(outValid), .outData(outData), .outLast(outLast),
        .tblWrEn(tblWrEn), .tblWrIndex(tblWrIndex),
        .tblWrValid(tblWrValid), .tblWrVid(tblWrVid),
        .tblWrMembers(tblWrMembers), .tblWrLearnOff(tblWrLearnOff),
        .portCfgWrEn(portCfgWrEn), .portCfgPvid(portCfgPvid),
        .portCfgPriority(portCfgPriority), .portCfgTagged(portCfgTagged),
        .portCfgFilter(portCfgFilter), .portCfgQinq(portCfgQinq),
        .portCfgServiceVid(portCfgServiceVid), .fwdValid(fwdValid),
        .fwdMask(fwdMask), .fwdDrop(fwdDrop), .fwdFlood(fwdFlood),
        .classVid(classVid), .learnValid(learnValid),
        .learnMac(learnMac), .learnVid(learnVid));
    vtc_link_partner vtc_link_partner_i (.clk(clk), .inReady(inReady),
        .outValid(outValid), .outData(outData), .inValid(inValid),
        .inData(inData), .inLast(inLast));

    always #2 clk = ~clk;

    function automatic vtc_bq_t mk(input [31:0] t1, t2, input int nt, pay);
        vtc_bq_t q;
        logic [95:0] mac;
        logic [63:0] tt;
        mac = {48'hFFFFFFFFFFFF, srcMac};
        tt = {t1, t2};
        for (int i = 0; i < 12; i++) q.push_back(mac[95-8*i -: 8]);
        for (int i = 0; i < 4 * nt; i++) q.push_back(tt[63-8*i -: 8]);
        q.push_back(8'h08);
        q.push_back(8'h00);
        for (int i = 0; i < pay; i++) q.push_back(8'(i + 1));
        return q;
    endfunction

    function automatic [31:0] fcs(input vtc_bq_t b);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (b[i]) begin
            c = c ^ {24'h000000, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction

    task automatic chk(input [63:0] got, input [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chkq(input vtc_bq_t got, input vtc_bq_t exp);
        logic bad;
        bad = got.size() != exp.size();
        foreach (exp[i]) begin
            if (i < got.size() && got[i] !== exp[i]) bad = 1'b1;
        end
        checked++;
        if (bad) begin
            n_fail++;
            $display("[FAIL] %0t frame of %0d bytes, want %0d", $time,
                got.size(), exp.size());
        end
    endtask

    task automatic cfg(input [11:0] pv, input [2:0] pr, input tg, fl,
        input [1:0] qq, input [11:0] sv);
        @(negedge clk);
        {portCfgPvid, portCfgPriority, portCfgTagged} = {pv, pr, tg};
        {portCfgFilter, portCfgQinq, portCfgServiceVid} = {fl, qq, sv};
        portCfgWrEn = 1'b1;
        @(negedge clk);
        portCfgWrEn = 1'b0;
    endtask

    task automatic tbl(input [7:0] ix, input [11:0] vid, input [7:0] mb,
        input lo);
        @(negedge clk);
        {tblWrIndex, tblWrVid, tblWrMembers, tblWrLearnOff} = {ix, vid, mb, lo};
        tblWrEn = 1'b1;
        @(negedge clk);
        tblWrEn = 1'b0;
    endtask

    task automatic run(input vtc_bq_t fi, input vtc_bq_t fe,
        input [11:0] vE, input [7:0] mE, input dE, input flE);
        int k;
        logic [31:0] c;
        vtc_link_partner_i.rxq.delete();
        vtc_link_partner_i.txq = fi;
        k = 0;
        while (fwdValid !== 1'b1 && k < 200) begin
            @(negedge clk);
            k++;
        end
        chk({fwdDrop, fwdFlood, fwdMask, classVid}, {dE, flE, mE, vE});
        if (!dE) begin
            if (flE) chk(learnValid, 1'b0);
            else chk({learnValid, learnVid, learnMac}, {1'b1, vE, srcMac});
            k = 0;
            while (outLast !== 1'b1 && k < 400) begin
                @(negedge clk);
                k++;
            end
            @(negedge clk);
            while (fe.size() < 60) fe.push_back(8'h00);
            c = fcs(fe);
            for (int i = 0; i < 4; i++) fe.push_back(c[8*i +: 8]);
        end else begin
            fe.delete();
            repeat (30) @(negedge clk);
        end
        chkq(vtc_link_partner_i.rxq, fe);
        @(negedge clk);
    endtask

    task automatic t_default();
        run(mk(0, 0, 0, 6), mk(0, 0, 0, 6), 12'h001, 8'hFE, 0, 0);
    endtask

    task automatic t_tag_strip();
        tbl(8'h01, 12'h005, 8'h07, 1'b0);
        run(mk(tagC5 | 32'h4000, 0, 1, 2), mk(0, 0, 0, 2), 12'h005,
            8'h06, 0, 0);
    endtask

    task automatic t_port_default_vlan_id_filter();
        cfg(12'h005, 3'h0, 1'b0, 1'b0, 2'h0, 12'h001);
        run(mk(0, 0, 0, 6), mk(0, 0, 0, 6), 12'h005, 8'h06, 0, 0);
        tbl(8'h01, 12'h005, 8'h06, 1'b0);
        cfg(12'h005, 3'h0, 1'b0, 1'b1, 2'h0, 12'h001);
        run(mk(0, 0, 0, 6), mk(0, 0, 0, 6), 12'h005, 8'h00, 1, 0);
    endtask

    task automatic t_tag_insert();
        cfg(12'h005, 3'h3, 1'b1, 1'b0, 2'h0, 12'h001);
        run(mk(0, 0, 0, 6), mk(tagC5 | 32'h6000, 0, 1, 6), 12'h005,
            8'h06, 0, 0);
        run(mk(tagC5 | 32'h4000, 0, 1, 2), mk(tagC5 | 32'h4000, 0, 1, 2),
            12'h005, 8'h06, 0, 0);
    endtask

    task automatic t_vid_limit();
        tbl(8'hFE, 12'hFFE, 8'h03, 1'b0);
        run(mk(tagC5 ^ 32'h0FFB, 0, 1, 2), mk(tagC5 ^ 32'h0FFB, 0, 1, 2),
            12'hFFE, 8'h02, 0, 0);
        tbl(8'h03, 12'hFFF, 8'hFF, 1'b0);
        run(mk(tagC5 ^ 32'h0FFA, 0, 1, 2), mk(0, 0, 0, 0), 12'hFFF,
            8'h00, 1, 0);
        tbl(8'hFF, 12'h009, 8'hFF, 1'b0);
        run(mk(tagC5 ^ 32'h000C, 0, 1, 2), mk(0, 0, 0, 0), 12'h009,
            8'h00, 1, 0);
        tblWrValid = 1'b0;
        tbl(8'hFE, 12'hFFE, 8'h03, 1'b0);
        tblWrValid = 1'b1;
        run(mk(tagC5 ^ 32'h0FFB, 0, 1, 2), mk(0, 0, 0, 0), 12'hFFE,
            8'h00, 1, 0);
    endtask

    task automatic t_qinq();
        tbl(8'h02, 12'h007, 8'h03, 1'b1);
        cfg(12'h001, 3'h0, 1'b1, 1'b0, 2'h1, 12'h007);
        run(mk(tagC5, 0, 1, 2), mk(tagS7, tagC5, 2, 2), 12'h005,
            8'h06, 0, 0);
        cfg(12'h001, 3'h0, 1'b1, 1'b0, 2'h2, 12'h007);
        run(mk(tagS7, tagC5, 2, 2), mk(tagC5, 0, 1, 2), 12'h007,
            8'h02, 0, 1);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        {clk, rst_n, tblWrEn, tblWrValid, tblWrLearnOff, portCfgWrEn} = '0;
        {tblWrIndex, tblWrVid, tblWrMembers} = '0;
        {portCfgPvid, portCfgPriority, portCfgTagged} = '0;
        {portCfgFilter, portCfgQinq, portCfgServiceVid} = '0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        tblWrValid = 1'b1;
        @(negedge clk);
        t_default();
        t_tag_strip();
        t_port_default_vlan_id_filter();
        t_tag_insert();
        t_vid_limit();
        t_qinq();
        print_verdict();
    end
endmodule
